//--- logic/shutter_io_cfg.svh
// register offsets, field positions and reset values of the shutter i/o block
`ifndef SHUTTER_IO_CFG_SVH
`define SHUTTER_IO_CFG_SVH

// ==========================================
// register byte offsets
`define SIO_CTRL_OFS      8'h00
`define SIO_STATUS_OFS    8'h04
`define SIO_IRQ_STAT_OFS  8'h08
`define SIO_IRQ_MASK_OFS  8'h0C

// ==========================================
// control register fields
`define SIO_CTRL_RES_BIT    0
`define SIO_CTRL_BR_LSB     1
`define SIO_CTRL_INDEP_BIT  5
`define SIO_CTRL_GUIDE_BIT  6
`define SIO_CTRL_LASER_BIT  7
`define SIO_CTRL_RST        8'h00

// ==========================================
// status register fields
`define SIO_ST_RES_BIT    0
`define SIO_ST_BR_LSB     1
`define SIO_ST_TS_LSB     5
`define SIO_ST_ESTOP_BIT  8
`define SIO_ST_ILK_BIT    9
`define SIO_ST_KEY_BIT    10

// ==========================================
// interrupt status and mask fields
`define SIO_EV_ESTOP_BIT  0
`define SIO_EV_ILK_BIT    1
`define SIO_EV_TSREJ_BIT  2
`define SIO_IRQ_MASK_RST  3'h0

// ==========================================
// bus responses
`define SIO_RESP_OKAY     2'h0
`define SIO_RESP_SLVERR   2'h2

`endif

//--- logic/shutter_io_pkg.sv
// types and fixed widths shared by the shutter i/o block
package shutter_io_pkg;

  // ==========================================
  // fixed channel counts
  localparam int NUM_BRANCH = 4;
  localparam int NUM_TS     = 3;
  localparam int NUM_EV     = 3;

  // ==========================================
  // operating modes of the laser control path
  typedef enum logic [1:0] {
    MODE_KEYOFF,
    MODE_RUN,
    MODE_ESTOP
  } op_mode_t;

endpackage : shutter_io_pkg

//--- logic/input_sync.sv
// three-flop synchroniser bank for contact inputs
`timescale 1ns/100ps

module input_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // ==========================================
  // per bit: take the new level once stages two and three agree
  for (genvar b = 0; b < W; b++) begin : g_bit
    always_comb begin
      q_next[b] = (s2_reg[b] == s3_reg[b]) ? s3_reg[b] : q_reg[b];
    end
  end

  // shift chain, first stage read only by the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      q_reg  <= RST_VAL;
    end else begin
      s1_reg <= i_d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign o_q = q_reg;

endmodule : input_sync

//--- logic/event_latch.sv
// sticky event bits with write-one-to-clear, mask and level interrupt
`timescale 1ns/100ps

module event_latch #(
  parameter int           W        = 1,
  parameter logic [W-1:0] MASK_RST = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_set,
  input  wire logic         i_clr_we,
  input  wire logic [W-1:0] i_clr_data,
  input  wire logic         i_mask_we,
  input  wire logic [W-1:0] i_mask_data,
  output logic      [W-1:0] o_stat,
  output logic      [W-1:0] o_mask,
  output logic              o_irq
);

  logic [W-1:0] stat_reg;
  logic [W-1:0] stat_next;
  logic [W-1:0] mask_reg;
  logic [W-1:0] mask_next;
  logic         irq_reg;
  logic         irq_next;

  // ==========================================
  // set wins over a clear in the same cycle
  always_comb begin
    stat_next = stat_reg;
    if (i_clr_we) begin
      stat_next = stat_next & ~i_clr_data;
    end
    stat_next = stat_next | i_set;
    mask_next = i_mask_we ? i_mask_data : mask_reg;
    irq_next  = |(stat_next & mask_next);
  end

  // state registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stat_reg <= '0;
      mask_reg <= MASK_RST;
      irq_reg  <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg  <= irq_next;
    end
  end

  assign o_stat = stat_reg;
  assign o_mask = mask_reg;
  assign o_irq  = irq_reg;

endmodule : event_latch

//--- logic/shutter_status_estop_interlock_io.sv
// shutter status, timesharing, emergency stop and interlock contact logic
`timescale 1ns/100ps
`include "shutter_io_cfg.svh"

// How it works
// - timesharing requests honoured only under independent control
// - resonator open status follows resonator shutter
// - four branch open outputs follow their shutters
// - three timesharing on outputs follow unit drive
// - open stop input loop halts laser, enters stop
// - stop state acts as key switch off
// - any stop opens the stop output loop
// - open interlock closes shutters, stops guide, laser
module shutter_status_estop_interlock_io
  import shutter_io_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // contact inputs from the machine controller and safety wiring
  input  wire logic [NUM_TS-1:0]     i_ts_req,
  input  wire logic                  i_estop_in_closed,
  input  wire logic                  i_interlock_closed,
  input  wire logic                  i_key_on,
  // mechanical position sensing of the shutters
  input  wire logic                  i_res_shutter_open_fb,
  input  wire logic [NUM_BRANCH-1:0] i_branch_open_fb,
  // drives into the optics
  output logic                       o_res_shutter_cmd,
  output logic [NUM_BRANCH-1:0]      o_branch_shutter_cmd,
  output logic [NUM_TS-1:0]          o_ts_drive,
  output logic                       o_laser_en,
  output logic                       o_guide_en,
  // status contacts toward the machine controller
  output logic                       o_res_open_stat,
  output logic [NUM_BRANCH-1:0]      o_branch_open_stat,
  output logic [NUM_TS-1:0]          o_ts_on_stat,
  output logic                       o_estop_out_closed,
  output logic                       o_irq,
  // axi4-lite register port
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [7:0]            i_awaddr,
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  output logic [1:0]                 o_bresp,
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  input  wire logic [7:0]            i_araddr,
  output logic                       o_rvalid,
  input  wire logic                  i_rready,
  output logic [31:0]                o_rdata,
  output logic [1:0]                 o_rresp
);

  localparam int NSYNC = NUM_TS + NUM_BRANCH + 4;

  // ==========================================
  // signals
  logic [NSYNC-1:0]      sync_in, sync_out;
  logic [NUM_TS-1:0]     ts_req_s;
  logic                  estop_closed_s, ilk_closed_s, key_on_s, res_fb_s;
  logic [NUM_BRANCH-1:0] br_fb_s;

  op_mode_t              mode_reg, mode_next;
  logic [7:0]            ctrl_reg, ctrl_next;
  logic [NUM_TS-1:0]     ts_prev_reg;
  logic                  ilk_prev_reg;

  logic                  res_cmd_reg, res_cmd_next;
  logic [NUM_BRANCH-1:0] br_cmd_reg, br_cmd_next;
  logic [NUM_TS-1:0]     ts_drv_reg, ts_drv_next;
  logic                  laser_reg, laser_next;
  logic                  guide_reg, guide_next;
  logic                  res_st_reg;
  logic [NUM_BRANCH-1:0] br_st_reg;
  logic                  estop_out_reg, estop_out_next;
  logic                  permit;

  logic [NUM_EV-1:0]     ev_set, ev_stat, ev_mask;
  logic                  irq_w;

  logic                  aw_full_reg, aw_full_next;
  logic [7:0]            aw_addr_reg, aw_addr_next;
  logic                  w_full_reg, w_full_next;
  logic [31:0]           w_data_reg, w_data_next;
  logic                  w_strb0_reg, w_strb0_next;
  logic                  bvalid_reg, bvalid_next;
  logic [1:0]            bresp_reg, bresp_next;
  logic                  awready_reg, awready_next;
  logic                  wready_reg, wready_next;
  logic                  arready_reg, arready_next;
  logic                  rvalid_reg, rvalid_next;
  logic [31:0]           rdata_reg, rdata_next;
  logic [1:0]            rresp_reg, rresp_next;
  logic                  do_write, wr_ctrl, wr_clr, wr_mask;
  logic [31:0]           status_word;

  // ==========================================
  // contact input synchronisers, safety loops reset to open
  assign sync_in = {i_ts_req, i_branch_open_fb, i_res_shutter_open_fb,
                    i_key_on, i_interlock_closed, i_estop_in_closed};

  input_sync #(
    .W       (NSYNC),
    .RST_VAL ('0)
  ) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   (sync_in),
    .o_q   (sync_out)
  );

  // split the synchronised bank
  assign estop_closed_s = sync_out[0];
  assign ilk_closed_s   = sync_out[1];
  assign key_on_s       = sync_out[2];
  assign res_fb_s       = sync_out[3];
  assign br_fb_s        = sync_out[4 +: NUM_BRANCH];
  assign ts_req_s       = sync_out[4 + NUM_BRANCH +: NUM_TS];

  // ==========================================
  // operating mode: an open stop loop wins from any mode
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      MODE_KEYOFF, MODE_RUN: mode_next = key_on_s ? MODE_RUN : MODE_KEYOFF;
      // leave stop only with loop closed and key turned off
      MODE_ESTOP: mode_next = (estop_closed_s && !key_on_s) ? MODE_KEYOFF : MODE_ESTOP;
      default:    mode_next = MODE_ESTOP; // unused code falls back to stop
    endcase
    if (!estop_closed_s) begin
      mode_next = MODE_ESTOP;
    end
  end

  // ==========================================
  // output drives: stop and interlock gate everything
  always_comb begin
    permit         = (mode_next == MODE_RUN) && ilk_closed_s;
    res_cmd_next   = permit && ctrl_reg[`SIO_CTRL_RES_BIT];
    br_cmd_next    = permit ? ctrl_reg[`SIO_CTRL_BR_LSB +: NUM_BRANCH] : '0;
    ts_drv_next    = (permit && ctrl_reg[`SIO_CTRL_INDEP_BIT]) ? ts_req_s : '0;
    laser_next     = permit && ctrl_reg[`SIO_CTRL_LASER_BIT];
    guide_next     = permit && ctrl_reg[`SIO_CTRL_GUIDE_BIT];
    estop_out_next = (mode_next != MODE_ESTOP);
  end

  // ==========================================
  // events: stop entry, interlock opening, refused request
  always_comb begin
    ev_set = '0;
    ev_set[`SIO_EV_ESTOP_BIT] = (mode_next == MODE_ESTOP) && (mode_reg != MODE_ESTOP);
    ev_set[`SIO_EV_ILK_BIT]   = ilk_prev_reg && !ilk_closed_s;
    ev_set[`SIO_EV_TSREJ_BIT] = |(ts_req_s & ~ts_prev_reg & ~ts_drv_next);
  end

  event_latch #(
    .W        (NUM_EV),
    .MASK_RST (`SIO_IRQ_MASK_RST)
  ) u_events (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_set       (ev_set),
    .i_clr_we    (wr_clr),
    .i_clr_data  (w_data_reg[NUM_EV-1:0]),
    .i_mask_we   (wr_mask),
    .i_mask_data (w_data_reg[NUM_EV-1:0]),
    .o_stat      (ev_stat),
    .o_mask      (ev_mask),
    .o_irq       (irq_w)
  );

  // ==========================================
  // axi4-lite write: address and data taken in either order
  always_comb begin
    do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    wr_ctrl  = do_write && w_strb0_reg && (aw_addr_reg == `SIO_CTRL_OFS);
    wr_clr   = do_write && w_strb0_reg && (aw_addr_reg == `SIO_IRQ_STAT_OFS);
    wr_mask  = do_write && w_strb0_reg && (aw_addr_reg == `SIO_IRQ_MASK_OFS);
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next  = w_full_reg;
    w_data_next  = w_data_reg;
    w_strb0_next = w_strb0_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (i_awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      aw_addr_next = i_awaddr;
    end
    if (i_wvalid && wready_reg) begin
      w_full_next  = 1'b1;
      w_data_next  = i_wdata;
      w_strb0_next = i_wstrb[0];
    end
    if (bvalid_reg && i_bready) begin
      bvalid_next = 1'b0;
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      unique case (aw_addr_reg)
        `SIO_CTRL_OFS, `SIO_STATUS_OFS,
        `SIO_IRQ_STAT_OFS, `SIO_IRQ_MASK_OFS: bresp_next = `SIO_RESP_OKAY;
        default:                               bresp_next = `SIO_RESP_SLVERR;
      endcase
    end
    awready_next = !aw_full_next && !bvalid_next;
    wready_next  = !w_full_next && !bvalid_next;
    ctrl_next    = wr_ctrl ? w_data_reg[7:0] : ctrl_reg;
  end

  // ==========================================
  // axi4-lite read: one cycle from address to data
  always_comb begin
    status_word = '0;
    status_word[`SIO_ST_RES_BIT]               = res_st_reg;
    status_word[`SIO_ST_BR_LSB +: NUM_BRANCH]  = br_st_reg;
    status_word[`SIO_ST_TS_LSB +: NUM_TS]      = ts_drv_reg;
    status_word[`SIO_ST_ESTOP_BIT]             = (mode_reg == MODE_ESTOP);
    status_word[`SIO_ST_ILK_BIT]               = !ilk_closed_s;
    status_word[`SIO_ST_KEY_BIT]               = key_on_s;
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (rvalid_reg && i_rready) begin
      rvalid_next = 1'b0;
    end
    if (i_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = `SIO_RESP_OKAY;
      unique case (i_araddr)
        `SIO_CTRL_OFS:     rdata_next = {24'h000000, ctrl_reg};
        `SIO_STATUS_OFS:   rdata_next = status_word;
        `SIO_IRQ_STAT_OFS: rdata_next = {29'h00000000, ev_stat};
        `SIO_IRQ_MASK_OFS: rdata_next = {29'h00000000, ev_mask};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = `SIO_RESP_SLVERR;
        end
      endcase
    end
    arready_next = !rvalid_next;
  end

  // ==========================================
  // registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_reg      <= MODE_ESTOP;
      ctrl_reg      <= `SIO_CTRL_RST;
      ts_prev_reg   <= '0;
      ilk_prev_reg  <= 1'b0;
      res_cmd_reg   <= 1'b0;
      br_cmd_reg    <= '0;
      ts_drv_reg    <= '0;
      laser_reg     <= 1'b0;
      guide_reg     <= 1'b0;
      res_st_reg    <= 1'b0;
      br_st_reg     <= '0;
      estop_out_reg <= 1'b0;
      aw_full_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_full_reg    <= 1'b0;
      w_data_reg    <= 32'h00000000;
      w_strb0_reg   <= 1'b0;
      bvalid_reg    <= 1'b0;
      bresp_reg     <= `SIO_RESP_OKAY;
      awready_reg   <= 1'b0;
      wready_reg    <= 1'b0;
      arready_reg   <= 1'b0;
      rvalid_reg    <= 1'b0;
      rdata_reg     <= 32'h00000000;
      rresp_reg     <= `SIO_RESP_OKAY;
    end else begin
      mode_reg      <= mode_next;
      ctrl_reg      <= ctrl_next;
      ts_prev_reg   <= ts_req_s;
      ilk_prev_reg  <= ilk_closed_s;
      res_cmd_reg   <= res_cmd_next;
      br_cmd_reg    <= br_cmd_next;
      ts_drv_reg    <= ts_drv_next;
      laser_reg     <= laser_next;
      guide_reg     <= guide_next;
      res_st_reg    <= res_fb_s;
      br_st_reg     <= br_fb_s;
      estop_out_reg <= estop_out_next;
      aw_full_reg   <= aw_full_next;
      aw_addr_reg   <= aw_addr_next;
      w_full_reg    <= w_full_next;
      w_data_reg    <= w_data_next;
      w_strb0_reg   <= w_strb0_next;
      bvalid_reg    <= bvalid_next;
      bresp_reg     <= bresp_next;
      awready_reg   <= awready_next;
      wready_reg    <= wready_next;
      arready_reg   <= arready_next;
      rvalid_reg    <= rvalid_next;
      rdata_reg     <= rdata_next;
      rresp_reg     <= rresp_next;
    end
  end

  // ==========================================
  // outputs, all from flops
  assign o_res_shutter_cmd    = res_cmd_reg;
  assign o_branch_shutter_cmd = br_cmd_reg;
  assign o_ts_drive           = ts_drv_reg;
  assign o_laser_en           = laser_reg;
  assign o_guide_en           = guide_reg;
  assign o_res_open_stat      = res_st_reg;
  assign o_branch_open_stat   = br_st_reg;
  assign o_ts_on_stat         = ts_drv_reg;
  assign o_estop_out_closed   = estop_out_reg;
  assign o_irq                = irq_w;
  assign o_awready            = awready_reg;
  assign o_wready             = wready_reg;
  assign o_bvalid             = bvalid_reg;
  assign o_bresp              = bresp_reg;
  assign o_arready            = arready_reg;
  assign o_rvalid             = rvalid_reg;
  assign o_rdata              = rdata_reg;
  assign o_rresp              = rresp_reg;

endmodule : shutter_status_estop_interlock_io

//--- verification/shutter_plant_model.sv
// shutter mechanics model: sensors follow open commands after travel time
`timescale 1ns/100ps

module shutter_plant_model
  import shutter_io_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_slow,
  input  wire logic                  i_res_cmd,
  input  wire logic [NUM_BRANCH-1:0] i_branch_cmd,
  output logic                       o_res_fb,
  output logic [NUM_BRANCH-1:0]      o_branch_fb
);
  logic [7:0][NUM_BRANCH:0] travel_reg;
  logic [7:0][NUM_BRANCH:0] travel_next;

  // ==========================================
  // travel pipeline, one stage per cycle
  always_comb begin
    travel_next = {travel_reg[6:0], i_branch_cmd, i_res_cmd};
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      travel_reg <= '0;
    end else begin
      travel_reg <= travel_next;
    end
  end

  // prompt shutters report after one cycle, slow ones after eight
  assign {o_branch_fb, o_res_fb} = i_slow ? travel_reg[7] : travel_reg[0];
endmodule : shutter_plant_model

//--- verification/shutter_io_properties.sv
// concurrent checks on the shutter i/o block ports
`timescale 1ns/100ps

module shutter_io_properties
  import shutter_io_pkg::*;
(
  input wire logic                  i_clk,
  input wire logic                  i_rst,
  input wire logic                  i_estop_in_closed,
  input wire logic                  i_interlock_closed,
  input wire logic                  i_res_shutter_open_fb,
  input wire logic [NUM_BRANCH-1:0] i_branch_open_fb,
  input wire logic                  i_arvalid,
  input wire logic                  i_bready,
  input wire logic                  o_arready,
  input wire logic                  o_rvalid,
  input wire logic                  o_bvalid,
  input wire logic [1:0]            o_bresp,
  input wire logic                  o_res_shutter_cmd,
  input wire logic [NUM_BRANCH-1:0] o_branch_shutter_cmd,
  input wire logic [NUM_TS-1:0]     o_ts_drive,
  input wire logic                  o_laser_en,
  input wire logic                  o_guide_en,
  input wire logic                  o_res_open_stat,
  input wire logic [NUM_BRANCH-1:0] o_branch_open_stat,
  input wire logic [NUM_TS-1:0]     o_ts_on_stat,
  input wire logic                  o_estop_out_closed
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ==========================================
  // stop and interlock
  estop_drives_a:
    assert property (!i_estop_in_closed [*7] |=> !o_laser_en && !o_res_shutter_cmd
      && o_branch_shutter_cmd == '0 && o_ts_drive == '0) else $error("drive in stop");
  estop_loop_a:
    assert property (!i_estop_in_closed [*7] |=> !o_estop_out_closed)
      else $error("stop loop still closed");
  stop_quiet_a:
    assert property (!o_estop_out_closed [*2] |-> !o_laser_en && o_ts_drive == '0)
      else $error("laser active in stop state");
  interlock_close_a:
    assert property (!i_interlock_closed [*7] |=> !o_res_shutter_cmd && !o_guide_en
      && !o_laser_en && o_branch_shutter_cmd == '0) else $error("drive with interlock open");

  // ==========================================
  // status contacts
  res_stat_a:
    assert property ($stable(i_res_shutter_open_fb) [*7] |=>
      o_res_open_stat == $past(i_res_shutter_open_fb)) else $error("resonator status wrong");
  branch_stat_a:
    assert property ($stable(i_branch_open_fb) [*7] |=>
      o_branch_open_stat == $past(i_branch_open_fb)) else $error("branch status wrong");
  ts_stat_a:
    assert property (o_ts_on_stat == o_ts_drive) else $error("ts status differs");

  // ==========================================
  // register bus answers
  read_answer_a:
    assert property (i_arvalid && o_arready |=> o_rvalid) else $error("read not answered");
  write_hold_a:
    assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped");

  cover property (!o_estop_out_closed ##1 o_estop_out_closed);
  cover property (o_ts_drive != '0);
  cover property (!i_interlock_closed && o_branch_open_stat == '0);
endmodule : shutter_io_properties

bind shutter_status_estop_interlock_io shutter_io_properties i_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_estop_in_closed(i_estop_in_closed),
  .i_interlock_closed(i_interlock_closed), .i_res_shutter_open_fb(i_res_shutter_open_fb),
  .i_branch_open_fb(i_branch_open_fb), .i_arvalid(i_arvalid), .i_bready(i_bready),
  .o_arready(o_arready), .o_rvalid(o_rvalid), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
  .o_res_shutter_cmd(o_res_shutter_cmd), .o_branch_shutter_cmd(o_branch_shutter_cmd),
  .o_ts_drive(o_ts_drive), .o_laser_en(o_laser_en), .o_guide_en(o_guide_en),
  .o_res_open_stat(o_res_open_stat), .o_branch_open_stat(o_branch_open_stat),
  .o_ts_on_stat(o_ts_on_stat), .o_estop_out_closed(o_estop_out_closed));

//--- verification/shutter_status_estop_interlock_io_tb.sv
// self-checking bench for the shutter i/o block
`timescale 1ns/100ps
`include "shutter_io_cfg.svh"

module shutter_status_estop_interlock_io_tb
  import shutter_io_pkg::*;
;
  logic                  i_clk = 1'b0;
  logic                  i_rst = 1'b1;
  logic [NUM_TS-1:0]     ts_req = '0;
  logic                  estop_closed = 1'b1;
  logic                  ilk_closed = 1'b1;
  logic                  key_on = 1'b0;
  logic                  slow = 1'b0;
  logic                  res_fb, res_cmd, laser, guide, res_st, estop_out, irq;
  logic [NUM_BRANCH-1:0] br_fb, br_cmd, br_st;
  logic [NUM_TS-1:0]     ts_drv, ts_st;
  logic                  awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic                  awr, wr, bv, arr, rv;
  logic [7:0]            awa = '0, ara = '0;
  logic [31:0]           wd = '0, rd, v;
  logic [3:0]            wst = '0;
  logic [1:0]            br, rr, resp;
  int                    n_errors = 0, n_compared = 0;

  always #10 i_clk = ~i_clk;

  shutter_status_estop_interlock_io i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ts_req(ts_req), .i_estop_in_closed(estop_closed),
    .i_interlock_closed(ilk_closed), .i_key_on(key_on), .i_res_shutter_open_fb(res_fb),
    .i_branch_open_fb(br_fb), .o_res_shutter_cmd(res_cmd), .o_branch_shutter_cmd(br_cmd),
    .o_ts_drive(ts_drv), .o_laser_en(laser), .o_guide_en(guide), .o_res_open_stat(res_st),
    .o_branch_open_stat(br_st), .o_ts_on_stat(ts_st), .o_estop_out_closed(estop_out),
    .o_irq(irq), .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv),
    .o_wready(wr), .i_wdata(wd), .i_wstrb(wst), .o_bvalid(bv), .i_bready(bready),
    .o_bresp(br), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv),
    .i_rready(rready), .o_rdata(rd), .o_rresp(rr));

  shutter_plant_model i_plant (
    .i_clk(i_clk), .i_rst(i_rst), .i_slow(slow), .i_res_cmd(res_cmd),
    .i_branch_cmd(br_cmd), .o_res_fb(res_fb), .o_branch_fb(br_fb));

  // ==========================================
  // comparison, bus tasks and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen 0x%08h expected 0x%08h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int   n;
    logic aw_left, w_left;
    @(posedge i_clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    wst <= 4'hF;
    aw_left = 1'b1;
    w_left = 1'b1;
    n = 0;
    while ((aw_left || w_left) && n < 100) begin
      @(posedge i_clk);
      n++;
      if (aw_left && awr) begin
        aw_left = 1'b0;
        awv <= 1'b0;
      end
      if (w_left && wr) begin
        w_left = 1'b0;
        wv <= 1'b0;
      end
    end
    while (!bv && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    // late bready: the response must hold one stalled cycle
    bready <= 1'b1;
    @(posedge i_clk);
    r = br;
    bready <= 1'b0;
    if (n >= 100) n_errors++;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge i_clk);
    arv <= 1'b1;
    ara <= a;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (!arr && n < 100);
    arv <= 1'b0;
    do begin
      @(posedge i_clk);
      n++;
    end while (!rv && n < 100);
    d = rd;
    r = rr;
    rready <= 1'b0;
    if (n >= 100) n_errors++;
  endtask : axi_rd

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // ==========================================
  // watchdog, several times the expected run
  initial begin
    repeat (5000) @(posedge i_clk);
    n_errors++;
    end_of_test();
  end

  // ==========================================
  // test sequence
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    axi_rd(`SIO_CTRL_OFS, v, resp);
    check(v, 32'(`SIO_CTRL_RST));
    axi_rd(`SIO_IRQ_MASK_OFS, v, resp);
    check(v, 32'(`SIO_IRQ_MASK_RST));
    axi_rd(8'h10, v, resp);
    check(v, 32'h0);
    check(32'(resp), 32'(`SIO_RESP_SLVERR));
    axi_wr(8'h10, 32'hFF, resp);
    check(32'(resp), 32'(`SIO_RESP_SLVERR));
    $display("test registers done");
    key_on <= 1'b1;
    repeat (10) @(posedge i_clk);
    axi_wr(`SIO_CTRL_OFS, 32'hDF, resp);
    repeat (4) @(posedge i_clk);
    check(32'({laser, guide, br_cmd, res_cmd}), 32'h7F);
    repeat (10) @(posedge i_clk);
    check(32'({br_st, res_st}), 32'h1F);
    axi_rd(`SIO_STATUS_OFS, v, resp);
    check(v, 32'h41F);
    $display("test run done");
    ts_req <= 3'h5;
    repeat (8) @(posedge i_clk);
    check(32'(ts_drv), 32'h0);
    axi_rd(`SIO_IRQ_STAT_OFS, v, resp);
    check(v, 32'h4);
    check(32'(irq), 32'h0);
    axi_wr(`SIO_IRQ_MASK_OFS, 32'h7, resp);
    repeat (2) @(posedge i_clk);
    check(32'(irq), 32'h1);
    axi_wr(`SIO_IRQ_STAT_OFS, 32'h4, resp);
    repeat (2) @(posedge i_clk);
    check(32'(irq), 32'h0);
    axi_wr(`SIO_CTRL_OFS, 32'hFF, resp);
    repeat (3) @(posedge i_clk);
    check(32'({ts_st, ts_drv}), 32'h2D);
    ts_req <= 3'h0;
    repeat (8) @(posedge i_clk);
    check(32'({ts_st, ts_drv}), 32'h0);
    $display("test timesharing done");
    slow <= 1'b1;
    ilk_closed <= 1'b0;
    repeat (8) @(posedge i_clk);
    check(32'({laser, guide, br_cmd, res_cmd}), 32'h0);
    repeat (16) @(posedge i_clk);
    check(32'({br_st, res_st}), 32'h0);
    axi_rd(`SIO_IRQ_STAT_OFS, v, resp);
    check(v, 32'h2);
    axi_rd(`SIO_STATUS_OFS, v, resp);
    check(v, 32'h600);
    ilk_closed <= 1'b1;
    repeat (8) @(posedge i_clk);
    check(32'({laser, guide, br_cmd, res_cmd}), 32'h7F);
    axi_wr(`SIO_IRQ_STAT_OFS, 32'h7, resp);
    $display("test interlock done");
    estop_closed <= 1'b0;
    repeat (8) @(posedge i_clk);
    check(32'({estop_out, laser, br_cmd, res_cmd}), 32'h0);
    axi_rd(`SIO_STATUS_OFS, v, resp);
    check(32'(v[10:8]), 32'h5);
    axi_rd(`SIO_IRQ_STAT_OFS, v, resp);
    check(v, 32'h1);
    estop_closed <= 1'b1;
    repeat (8) @(posedge i_clk);
    check(32'(estop_out), 32'h0);
    key_on <= 1'b0;
    repeat (8) @(posedge i_clk);
    check(32'(estop_out), 32'h1);
    key_on <= 1'b1;
    repeat (8) @(posedge i_clk);
    check(32'({laser, guide, br_cmd, res_cmd}), 32'h7F);
    $display("test stop done");
    end_of_test();
  end
endmodule : shutter_status_estop_interlock_io_tb
